// >>> logic/sacf_pkg.sv
// shared constants, types and helpers of the serial frame codec
package sacf_pkg;
   localparam logic [7:0] SACF_DELIM = 8'h7E;
   localparam logic [7:0] SACF_ESC = 8'h7D;
   localparam logic [7:0] SACF_XON = 8'h11;
   localparam logic [7:0] SACF_XOFF = 8'h13;
   localparam logic [7:0] SACF_ESC_XOR = 8'h20;
   localparam logic [7:0] SACF_CSUM_BASE = 8'hFF;
   localparam logic [7:0] SACF_CSUM_GOOD = 8'hFF;
   localparam logic [7:0] SACF_TYPE_CMD = 8'h08;
   localparam logic [7:0] SACF_TYPE_CMD_RSP = 8'h88;
   localparam logic [7:0] SACF_TYPE_STATUS = 8'h8A;
   localparam logic [7:0] SACF_ERR_CSUM = 8'h01;
   localparam logic [7:0] SACF_ERR_LEN = 8'h02;
   localparam logic [7:0] SACF_ST_OK = 8'h00;
   localparam logic [7:0] SACF_NO_RSP_ID = 8'h00;
   localparam logic [7:0] SACF_LEN_HI_ZERO = 8'h00;
   localparam logic [1:0] SACF_MODE_TRANSP = 2'h0;
   localparam logic [1:0] SACF_MODE_PLAIN = 2'h1;
   localparam logic [1:0] SACF_MODE_ESC = 2'h2;
   // byte positions inside frame data
   localparam logic [15:0] SACF_POS_TYPE = 16'h0000;
   localparam logic [15:0] SACF_POS_ID = 16'h0001;
   localparam logic [15:0] SACF_POS_NAME_HI = 16'h0002;
   localparam logic [15:0] SACF_POS_NAME_LO = 16'h0003;
   localparam logic [15:0] SACF_POS_PARAM = 16'h0004;
   // positions of the serialised frame before its data
   localparam logic [3:0] SACF_TX_DELIM = 4'h0;
   localparam logic [3:0] SACF_TX_LEN_HI = 4'h1;
   localparam logic [3:0] SACF_TX_LEN_LO = 4'h2;
   localparam logic [3:0] SACF_TX_DATA = 4'h3;
   localparam int SACF_FIFO_W = 8;
   localparam int SACF_FIFO_D = 16;
   localparam int SACF_TXB_N = 8;
   localparam logic [3:0] SACF_DEV_RSP_LEN = 4'h5;
   localparam logic [3:0] SACF_DEV_STAT_LEN = 4'h2;
   localparam logic [3:0] SACF_CMD_HDR_LEN = 4'h4;
   localparam logic [2:0] SACF_MAX_PARAM = 3'h4;

   typedef enum {SACF_RX_WAIT, SACF_RX_LEN_HI, SACF_RX_LEN_LO, SACF_RX_DATA,
      SACF_RX_CSUM} sacf_rx_st_t;

   function automatic logic sacf_needs_esc(input logic [7:0] b);
      return (b == SACF_DELIM) || (b == SACF_ESC) || (b == SACF_XON) || (b == SACF_XOFF);
   endfunction
endpackage

// >>> logic/sacf_link_if.sv
// serial byte link between host processor and device
`timescale 1ns/1ps
interface sacf_link_if;
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_ready;
   modport dev (input h2d_data, input h2d_valid, output h2d_ready,
      output d2h_data, output d2h_valid, input d2h_ready);
   modport host (output h2d_data, output h2d_valid, input h2d_ready,
      input d2h_data, input d2h_valid, output d2h_ready);
endinterface

// >>> logic/sacf_dev_end.sv
// device end of the serial frame codec: reply framer and command capture
`timescale 1ns/1ps
module sacf_dev_end
   import sacf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   sacf_link_if.dev link,
   input wire logic [1:0] host_framing_mode_select,
   input wire logic host_if_is_spi,
   output logic raw_rx_valid,
   output logic [7:0] raw_rx_data,
   output logic cmd_valid_r,
   output logic [7:0] cmd_id_r,
   output logic [15:0] cmd_name_r,
   output logic [31:0] cmd_param_r,
   output logic [2:0] cmd_param_len_r,
   output logic frame_valid_r,
   output logic [7:0] frame_type_r,
   output logic frame_err_r
);
   logic [1:0] mode_r;
   logic esc_on;
   logic rx_ready_r;
   logic db_valid;
   logic [7:0] db;
   logic [15:0] db_idx;
   logic done;
   logic ok;
   logic len_zero;
   logic [7:0] type_r;
   logic [7:0] id_r;
   logic [15:0] name_r;
   logic [31:0] param_r;
   logic [2:0] plen_r;
   logic [7:0] txb_r [SACF_TXB_N];
   logic [3:0] txn_r;
   logic tx_busy_r;
   logic [3:0] pos_r;
   logic half_r;
   logic [7:0] cur;
   logic [7:0] tsum;
   logic need_esc;
   logic fifo_in_valid;
   logic [7:0] fifo_in_data;
   logic fifo_in_ready;

   // mode is registered so reset forces transparent operation
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_r <= SACF_MODE_TRANSP;
      end else begin
         mode_r <= host_framing_mode_select;
      end
   end
   // spi path falls back to plain framing in mode 2
   assign esc_on = (mode_r == SACF_MODE_ESC) && !host_if_is_spi;

   // stall the host while an answer is being framed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_ready_r <= 1'b0;
      end else begin
         rx_ready_r <= !tx_busy_r;
      end
   end
   assign link.h2d_ready = rx_ready_r;

   sacf_deframer u_rx (
      .clk(clk),
      .rst_n(rst_n),
      .mode(mode_r),
      .esc_on(esc_on),
      .in_fire(link.h2d_valid && rx_ready_r),
      .in_data(link.h2d_data),
      .db_valid_r(db_valid),
      .db_r(db),
      .db_idx_r(db_idx),
      .done_r(done),
      .ok_r(ok),
      .len_zero_r(len_zero),
      .raw_valid_r(raw_rx_valid),
      .raw_r(raw_rx_data)
   );

   // fields held aside until the checksum has been judged
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         type_r <= '0;
         id_r <= '0;
         name_r <= '0;
         param_r <= '0;
         plen_r <= '0;
      end else if (db_valid) begin
         if (db_idx == SACF_POS_TYPE) begin
            type_r <= db;
            plen_r <= '0;
            param_r <= '0;
         end
         if (db_idx == SACF_POS_ID) id_r <= db;
         if (db_idx == SACF_POS_NAME_HI) name_r[15:8] <= db;
         if (db_idx == SACF_POS_NAME_LO) name_r[7:0] <= db;
         // parameter longer than four bytes keeps its last four
         if (db_idx >= SACF_POS_PARAM) begin
            param_r <= {param_r[23:0], db};
            if (plen_r != SACF_MAX_PARAM) plen_r <= plen_r + 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmd_valid_r <= 1'b0;
         cmd_id_r <= '0;
         cmd_name_r <= '0;
         cmd_param_r <= '0;
         cmd_param_len_r <= '0;
         frame_valid_r <= 1'b0;
         frame_type_r <= '0;
         frame_err_r <= 1'b0;
      end else begin
         cmd_valid_r <= 1'b0;
         frame_valid_r <= 1'b0;
         frame_err_r <= done && !ok;
         if (done && ok) begin
            frame_valid_r <= 1'b1;
            frame_type_r <= type_r;
            if (type_r == SACF_TYPE_CMD && db_idx >= SACF_POS_NAME_LO) begin
               cmd_valid_r <= 1'b1;
               cmd_id_r <= id_r;
               cmd_name_r <= name_r;
               cmd_param_r <= param_r;
               cmd_param_len_r <= plen_r;
            end
         end
      end
   end

   // tx byte at the current position, length never counts escapes
   always_comb begin
      tsum = '0;
      for (int i = 0; i < SACF_TXB_N; i++) begin
         if (4'(i) < txn_r) tsum = tsum + txb_r[i];
      end
      if (pos_r == SACF_TX_DELIM) cur = SACF_DELIM;
      else if (pos_r == SACF_TX_LEN_HI) cur = SACF_LEN_HI_ZERO;
      else if (pos_r == SACF_TX_LEN_LO) cur = {4'h0, txn_r};
      else if (pos_r < SACF_TX_DATA + txn_r) cur = txb_r[3'(pos_r - SACF_TX_DATA)];
      else cur = SACF_CSUM_BASE - tsum;
   end
   assign need_esc = esc_on && (pos_r != SACF_TX_DELIM) && sacf_needs_esc(cur);
   assign fifo_in_valid = tx_busy_r;
   assign fifo_in_data = (need_esc && !half_r) ? SACF_ESC :
      (need_esc ? (cur ^ SACF_ESC_XOR) : cur);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_busy_r <= 1'b0;
         pos_r <= '0;
         half_r <= 1'b0;
         txn_r <= '0;
         for (int i = 0; i < SACF_TXB_N; i++) txb_r[i] <= '0;
      end else if (!tx_busy_r) begin
         if (done && !ok) begin
            txb_r[0] <= SACF_TYPE_STATUS;
            txb_r[1] <= len_zero ? SACF_ERR_LEN : SACF_ERR_CSUM;
            txn_r <= SACF_DEV_STAT_LEN;
            tx_busy_r <= 1'b1;
            pos_r <= '0;
         end else if (done && type_r == SACF_TYPE_CMD && db_idx >= SACF_POS_NAME_LO &&
               id_r != SACF_NO_RSP_ID) begin
            txb_r[0] <= SACF_TYPE_CMD_RSP;
            txb_r[1] <= id_r;
            txb_r[2] <= name_r[15:8];
            txb_r[3] <= name_r[7:0];
            txb_r[4] <= SACF_ST_OK;
            txn_r <= SACF_DEV_RSP_LEN;
            tx_busy_r <= 1'b1;
            pos_r <= '0;
         end
      end else if (fifo_in_ready) begin
         if (need_esc && !half_r) begin
            half_r <= 1'b1;
         end else begin
            half_r <= 1'b0;
            pos_r <= pos_r + 4'h1;
            if (pos_r == SACF_TX_DATA + txn_r) tx_busy_r <= 1'b0;
         end
      end
   end

   // fifo absorbs the answer so a slow host only stalls the framer
   sacf_fifo #(.W(SACF_FIFO_W), .D(SACF_FIFO_D)) u_txq (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_data(fifo_in_data),
      .in_ready(fifo_in_ready),
      .out_valid(link.d2h_valid),
      .out_data(link.d2h_data),
      .out_ready(link.d2h_ready)
   );
endmodule

// >>> logic/sacf_host_end.sv
// host processor end, plus the byte fifo of the device end and the deframer both ends share
`timescale 1ns/1ps
module sacf_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] cnt_r;
   logic wr_en;
   logic rd_en;

   assign in_ready = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign wr_en = in_valid && in_ready;
   assign rd_en = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (wr_en) begin
            wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (rd_en) begin
            rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(wr_en) - (AW+1)'(rd_en);
      end
   end
endmodule

module sacf_deframer
   import sacf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] mode,
   input wire logic esc_on,
   input wire logic in_fire,
   input wire logic [7:0] in_data,
   output logic db_valid_r,
   output logic [7:0] db_r,
   output logic [15:0] db_idx_r,
   output logic done_r,
   output logic ok_r,
   output logic len_zero_r,
   output logic raw_valid_r,
   output logic [7:0] raw_r
);
   sacf_rx_st_t st_r;
   logic esc_r;
   logic [15:0] len_r;
   logic [15:0] cnt_r;
   logic [7:0] sum_r;
   logic [7:0] b_un;
   logic [7:0] sum_fin;

   assign b_un = esc_r ? (in_data ^ SACF_ESC_XOR) : in_data;
   assign sum_fin = sum_r + b_un;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= SACF_RX_WAIT;
         esc_r <= 1'b0;
         len_r <= '0;
         cnt_r <= '0;
         sum_r <= '0;
         db_valid_r <= 1'b0;
         db_r <= '0;
         db_idx_r <= '0;
         done_r <= 1'b0;
         ok_r <= 1'b0;
         len_zero_r <= 1'b0;
         raw_valid_r <= 1'b0;
         raw_r <= '0;
      end else begin
         db_valid_r <= 1'b0;
         done_r <= 1'b0;
         raw_valid_r <= 1'b0;
         if (in_fire) begin
            if (mode == SACF_MODE_TRANSP) begin
               raw_valid_r <= 1'b1;
               raw_r <= in_data;
               st_r <= SACF_RX_WAIT;
               esc_r <= 1'b0;
            end else if (esc_on && st_r != SACF_RX_WAIT && in_data == SACF_DELIM) begin
               // partial frame dropped without any answer
               st_r <= SACF_RX_LEN_HI;
               esc_r <= 1'b0;
            end else if (esc_on && !esc_r && in_data == SACF_ESC) begin
               esc_r <= 1'b1;
            end else begin
               esc_r <= 1'b0;
               unique case (st_r)
                  SACF_RX_WAIT: begin
                     if (in_data == SACF_DELIM) begin
                        st_r <= SACF_RX_LEN_HI;
                     end
                  end
                  SACF_RX_LEN_HI: begin
                     len_r <= {b_un, 8'h00};
                     st_r <= SACF_RX_LEN_LO;
                  end
                  SACF_RX_LEN_LO: begin
                     len_r <= {len_r[15:8], b_un};
                     cnt_r <= '0;
                     sum_r <= '0;
                     st_r <= ({len_r[15:8], b_un} == '0) ? SACF_RX_CSUM : SACF_RX_DATA;
                  end
                  SACF_RX_DATA: begin
                     sum_r <= sum_fin;
                     db_valid_r <= 1'b1;
                     db_r <= b_un;
                     db_idx_r <= cnt_r;
                     cnt_r <= cnt_r + 16'h0001;
                     if (cnt_r == len_r - 16'h0001) begin
                        st_r <= SACF_RX_CSUM;
                     end
                  end
                  SACF_RX_CSUM: begin
                     done_r <= 1'b1;
                     ok_r <= (sum_fin == SACF_CSUM_GOOD) && (len_r != '0);
                     len_zero_r <= (len_r == '0);
                     st_r <= SACF_RX_WAIT;
                  end
               endcase
            end
         end
      end
   end
endmodule

module sacf_host_end
   import sacf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   sacf_link_if.host link,
   input wire logic [1:0] host_framing_mode_select,
   input wire logic host_if_is_spi,
   input wire logic cmd_start,
   input wire logic [7:0] cmd_id,
   input wire logic [15:0] cmd_name,
   input wire logic [31:0] cmd_param,
   input wire logic [2:0] cmd_param_len,
   output logic cmd_busy_r,
   output logic rsp_valid_r,
   output logic [7:0] rsp_type_r,
   output logic [7:0] rsp_id_r,
   output logic [7:0] rsp_status_r,
   output logic rsp_bad_r
);
   logic esc_on;
   logic rx_ready_r;
   logic h2d_valid_r;
   logic [7:0] h2d_data_r;
   logic [7:0] txb_r [SACF_TXB_N];
   logic [3:0] txn_r;
   logic [3:0] pos_r;
   logic half_r;
   logic [7:0] cur;
   logic [7:0] tsum;
   logic need_esc;
   logic slot_free;
   logic db_valid;
   logic [7:0] db;
   logic [15:0] db_idx;
   logic done;
   logic ok;
   logic [7:0] type_r;
   logic [7:0] id_r;
   logic [7:0] st_r;

   assign esc_on = (host_framing_mode_select == SACF_MODE_ESC) && !host_if_is_spi;
   assign slot_free = !h2d_valid_r || link.h2d_ready;
   assign link.h2d_valid = h2d_valid_r;
   assign link.h2d_data = h2d_data_r;
   assign link.d2h_ready = rx_ready_r;

   always_comb begin
      tsum = '0;
      for (int i = 0; i < SACF_TXB_N; i++) begin
         if (4'(i) < txn_r) tsum = tsum + txb_r[i];
      end
      if (pos_r == SACF_TX_DELIM) cur = SACF_DELIM;
      else if (pos_r == SACF_TX_LEN_HI) cur = SACF_LEN_HI_ZERO;
      else if (pos_r == SACF_TX_LEN_LO) cur = {4'h0, txn_r};
      else if (pos_r < SACF_TX_DATA + txn_r) cur = txb_r[3'(pos_r - SACF_TX_DATA)];
      else cur = SACF_CSUM_BASE - tsum;
   end
   assign need_esc = esc_on && (pos_r != SACF_TX_DELIM) && sacf_needs_esc(cur);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmd_busy_r <= 1'b0;
         h2d_valid_r <= 1'b0;
         h2d_data_r <= '0;
         pos_r <= '0;
         half_r <= 1'b0;
         txn_r <= '0;
         for (int i = 0; i < SACF_TXB_N; i++) txb_r[i] <= '0;
      end else if (!cmd_busy_r) begin
         if (slot_free) h2d_valid_r <= 1'b0;
         // framing off in mode 0, so commands are ignored there
         if (cmd_start && host_framing_mode_select != SACF_MODE_TRANSP) begin
            txb_r[0] <= SACF_TYPE_CMD;
            txb_r[1] <= cmd_id;
            txb_r[2] <= cmd_name[15:8];
            txb_r[3] <= cmd_name[7:0];
            for (int i = 0; i < 4; i++) begin
               txb_r[4 + i] <= cmd_param[8 * (3 - i) +: 8];
            end
            txn_r <= SACF_CMD_HDR_LEN + {1'b0, (cmd_param_len > SACF_MAX_PARAM) ?
               SACF_MAX_PARAM : cmd_param_len};
            pos_r <= '0;
            half_r <= 1'b0;
            cmd_busy_r <= 1'b1;
         end
      end else if (slot_free) begin
         h2d_valid_r <= 1'b1;
         if (need_esc && !half_r) begin
            h2d_data_r <= SACF_ESC;
            half_r <= 1'b1;
         end else begin
            h2d_data_r <= need_esc ? (cur ^ SACF_ESC_XOR) : cur;
            half_r <= 1'b0;
            pos_r <= pos_r + 4'h1;
            if (pos_r == SACF_TX_DATA + txn_r) cmd_busy_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_ready_r <= 1'b0;
      end else begin
         rx_ready_r <= 1'b1;
      end
   end

   sacf_deframer u_rx (
      .clk(clk),
      .rst_n(rst_n),
      .mode(host_framing_mode_select),
      .esc_on(esc_on),
      .in_fire(link.d2h_valid && rx_ready_r),
      .in_data(link.d2h_data),
      .db_valid_r(db_valid),
      .db_r(db),
      .db_idx_r(db_idx),
      .done_r(done),
      .ok_r(ok),
      .len_zero_r(),
      .raw_valid_r(),
      .raw_r()
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         type_r <= '0;
         id_r <= '0;
         st_r <= '0;
      end else if (db_valid) begin
         if (db_idx == SACF_POS_TYPE) type_r <= db;
         if (db_idx == SACF_POS_ID) id_r <= db;
         if ((db_idx == SACF_POS_ID && type_r == SACF_TYPE_STATUS) ||
               (db_idx == SACF_POS_PARAM && type_r == SACF_TYPE_CMD_RSP)) begin
            st_r <= db;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_valid_r <= 1'b0;
         rsp_type_r <= '0;
         rsp_id_r <= '0;
         rsp_status_r <= '0;
         rsp_bad_r <= 1'b0;
      end else begin
         rsp_valid_r <= done && ok;
         rsp_bad_r <= done && !ok;
         if (done && ok) begin
            rsp_type_r <= type_r;
            rsp_id_r <= id_r;
            rsp_status_r <= st_r;
         end
      end
   end
endmodule

// >>> dv/sacf_link_sva.sv
// wire checks on the link between host and device ends
`timescale 1ns/1ps
module sacf_link_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [3:0] idx_r;
   wire tk = h2d_valid && h2d_ready;
   // host keeps valid up through a frame, so a low valid marks a frame gap
   always_ff @(posedge clk) begin
      if (!rst_n || !h2d_valid) idx_r <= 4'h0;
      else if (tk && idx_r != 4'hF) idx_r <= idx_r + 4'h1;
   end
   property p_rst;
      $rose(rst_n) |-> !h2d_valid && !d2h_valid;
   endproperty
   a_rst: assert property (p_rst) else $error("link busy after reset");
   property p_hold;
      h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
   endproperty
   a_hold: assert property (p_hold) else $error("host byte changed before taken");
   property p_delim;
      $rose(h2d_valid) |-> h2d_data == 8'h7E;
   endproperty
   a_delim: assert property (p_delim) else $error("host frame without delimiter");
   property p_len_hi;
      tk && idx_r == 4'h1 |-> h2d_data == 8'h00;
   endproperty
   a_len_hi: assert property (p_len_hi) else $error("length high byte wrong");
   property p_len_lo;
      tk && idx_r == 4'h2 |-> h2d_data inside {[8'h04:8'h08]};
   endproperty
   a_len_lo: assert property (p_len_lo) else $error("length low byte wrong");
   property p_type;
      tk && idx_r == 4'h3 |-> h2d_data == 8'h08;
   endproperty
   a_type: assert property (p_type) else $error("frame type wrong");
   property p_rdelim;
      $rose(d2h_valid) |-> d2h_data == 8'h7E;
   endproperty
   a_rdelim: assert property (p_rdelim) else $error("reply without delimiter");
   property p_stall;
      $rose(d2h_valid) |-> ##[0:2] !h2d_ready;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall while replying");
   property p_resume;
      $fell(h2d_ready) |-> ##[1:30] h2d_ready;
   endproperty
   a_resume: assert property (p_resume) else $error("receiver did not resume");
   c_type: cover property (tk && idx_r == 4'h3);
   c_reply: cover property ($rose(d2h_valid));
   c_stall: cover property (h2d_valid && !h2d_ready);
endmodule

// >>> dv/serial_api_frame_codec_bench.sv
// bench: host and device ends back to back, plus a second device end driven directly
`timescale 1ns/1ps
module serial_api_frame_codec_bench
   import sacf_pkg::*;
;
   logic clk, rst_n, spi, cmd_start, busy, rsp_v, rsp_bad, d_cmd, d_fv, d_err, e_cmd, e_err, e_raw;
   logic [1:0] mode, mode2;
   logic [7:0] c_id, r_type, r_id, r_st, d_id, d_type, e_id, raw_d;
   logic [15:0] c_name, d_name;
   logic [31:0] c_par, d_par;
   logic [2:0] c_pl, d_pl;
   int fails, checks, n_rsp, n_cmd, n_cmd2, n_err2, n_raw2, n_fv, n_bad;
   logic [7:0] hq[$], rq[$];
   sacf_link_if lk();
   sacf_link_if lk2();
   sacf_host_end sacf_host_end_inst (.clk(clk), .rst_n(rst_n), .link(lk),
      .host_framing_mode_select(mode), .host_if_is_spi(spi), .cmd_start(cmd_start),
      .cmd_id(c_id), .cmd_name(c_name), .cmd_param(c_par), .cmd_param_len(c_pl),
      .cmd_busy_r(busy), .rsp_valid_r(rsp_v), .rsp_type_r(r_type), .rsp_id_r(r_id),
      .rsp_status_r(r_st), .rsp_bad_r(rsp_bad));
   sacf_dev_end sacf_dev_end_inst (.clk(clk), .rst_n(rst_n), .link(lk),
      .host_framing_mode_select(mode), .host_if_is_spi(spi), .raw_rx_valid(), .raw_rx_data(),
      .cmd_valid_r(d_cmd), .cmd_id_r(d_id), .cmd_name_r(d_name), .cmd_param_r(d_par),
      .cmd_param_len_r(d_pl), .frame_valid_r(d_fv), .frame_type_r(d_type), .frame_err_r(d_err));
   // second device end lets the bench send malformed traffic
   sacf_dev_end sacf_dev_end_inst_b (.clk(clk), .rst_n(rst_n), .link(lk2),
      .host_framing_mode_select(mode2), .host_if_is_spi(1'b0), .raw_rx_valid(e_raw),
      .raw_rx_data(raw_d), .cmd_valid_r(e_cmd), .cmd_id_r(e_id), .cmd_name_r(),
      .cmd_param_r(), .cmd_param_len_r(), .frame_valid_r(), .frame_type_r(), .frame_err_r(e_err));
   sacf_link_sva sacf_link_sva_inst (.clk(clk), .rst_n(rst_n), .h2d_data(lk.h2d_data),
      .h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data),
      .d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (lk.h2d_valid === 1'b1 && lk.h2d_ready === 1'b1) hq.push_back(lk.h2d_data);
      if (lk2.d2h_valid === 1'b1 && lk2.d2h_ready === 1'b1) rq.push_back(lk2.d2h_data);
      if (rsp_v === 1'b1) n_rsp++;
      if (d_cmd === 1'b1) n_cmd++;
      if (e_cmd === 1'b1) n_cmd2++;
      if (e_err === 1'b1) n_err2++;
      if (e_raw === 1'b1) n_raw2++;
      if (d_fv === 1'b1) n_fv++;
      if (rsp_bad === 1'b1 || d_err === 1'b1) n_bad++;
   end
   task tick;
      @(posedge clk);
      #10;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task conclude;
      if (fails == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // mode is set while reset is held, so every mode change resets both ends
   task rst(input logic [1:0] m, input logic [1:0] m2, input logic s);
      rst_n = 0;
      mode = m;
      mode2 = m2;
      spi = s;
      repeat (3) tick;
      rst_n = 1;
      hq = {};
      rq = {};
      n_rsp = 0;
      n_cmd = 0;
      n_cmd2 = 0;
      n_err2 = 0;
      n_raw2 = 0;
      n_fv = 0;
      n_bad = 0;
      repeat (2) tick;
   endtask
   task cmd(input logic [7:0] id, input logic [31:0] p, input logic [2:0] pl);
      int k;
      hq = {};
      c_id = id;
      c_par = p;
      c_pl = pl;
      cmd_start = 1;
      tick;
      cmd_start = 0;
      k = 0;
      while (busy !== 1'b0 && k < 200) begin
         tick;
         k++;
      end
      chk("cmd busy", 0, busy);
      repeat (40) tick;
   endtask
   task snd(input logic [7:0] b);
      int k;
      lk2.h2d_data = b;
      lk2.h2d_valid = 1;
      k = 0;
      while (lk2.h2d_ready !== 1'b1 && k < 100) begin
         tick;
         k++;
      end
      chk("h2d ready", 1, lk2.h2d_ready);
      tick;
   endtask
   // a released line shows the inverse of its last byte, never a stale copy
   task frm(input logic [7:0] f[$]);
      foreach (f[i]) snd(f[i]);
      lk2.h2d_valid = 0;
      lk2.h2d_data = ~lk2.h2d_data;
      repeat (30) tick;
   endtask
   task wire_sum(input int n);
      logic [7:0] s;
      s = 0;
      chk("h2d size", n + 4, hq.size());
      chk("h2d delim", 8'h7E, hq[0]);
      chk("h2d len", n, {hq[1], hq[2]});
      for (int i = 3; i < hq.size(); i++) s += hq[i];
      chk("h2d sum", 8'hFF, s);
   endtask
   task rchk(input logic [7:0] code);
      chk("reply size", 6, rq.size());
      chk("reply type", 8'h8A, rq[3]);
      chk("reply code", code, rq[4]);
      chk("reply sum", 8'hFF - 8'h8A - code, rq[5]);
      rq = {};
   endtask
   initial begin
      rst_n = 0;
      cmd_start = 0;
      c_name = 16'h4142;
      lk2.h2d_valid = 0;
      lk2.h2d_data = 8'h00;
      lk2.d2h_ready = 1;
      fails = 0;
      checks = 0;
      rst(2'h0, 2'h0, 1'b0);
      cmd(8'h01, 32'h0, 3'h0);
      chk("mode0 h2d bytes", 0, hq.size());
      frm('{8'h55});
      chk("raw data", 8'h55, raw_d);
      chk("raw count", 1, n_raw2);
      rst(2'h1, 2'h1, 1'b0);
      cmd(8'h01, 32'h0, 3'h0);
      wire_sum(4);
      chk("h2d type", 8'h08, hq[3]);
      chk("cmd id", 8'h01, d_id);
      chk("cmd name", 16'h4142, d_name);
      chk("cmd plen", 3'h0, d_pl);
      chk("frame type", 8'h08, d_type);
      chk("rsp type", 8'h88, r_type);
      chk("rsp id", 8'h01, r_id);
      chk("rsp status", 8'h00, r_st);
      cmd(8'h02, 32'h0102_0304, 3'h4);
      wire_sum(8);
      chk("cmd param", 32'h0102_0304, d_par);
      chk("cmd plen", 3'h4, d_pl);
      cmd(8'h00, 32'h0, 3'h0);
      chk("silent cmd", 3, n_cmd);
      chk("silent rsp", 2, n_rsp);
      chk("frame valid", 3, n_fv);
      chk("bad frames", 0, n_bad);
      frm('{8'h11, 8'h22, 8'h7E, 8'h00, 8'h04, 8'h08, 8'h05, 8'h41, 8'h42, 8'h00});
      chk("bad sum cmd", 0, n_cmd2);
      chk("bad sum err", 1, n_err2);
      rchk(8'h01);
      frm('{8'h7E, 8'h00, 8'h00, 8'hFF});
      rchk(8'h02);
      frm('{8'h33, 8'h7E, 8'h00, 8'h04, 8'h08, 8'h05, 8'h41, 8'h42, 8'h6F});
      chk("good cmd", 1, n_cmd2);
      chk("good id", 8'h05, e_id);
      chk("good err", 2, n_err2);
      rst(2'h2, 2'h2, 1'b0);
      cmd(8'h7D, 32'h7E11_1320, 3'h4);
      chk("esc size", 16, hq.size());
      chk("esc id", 8'h5D, hq[5]);
      chk("esc len", 8'h08, hq[2]);
      chk("dev id", 8'h7D, d_id);
      chk("dev param", 32'h7E11_1320, d_par);
      chk("rsp id", 8'h7D, r_id);
      chk("esc bad", 0, n_bad);
      frm('{8'h7E, 8'h00, 8'h04, 8'h08, 8'h7E, 8'h00, 8'h04, 8'h08, 8'h06, 8'h41, 8'h42,
         8'h6E});
      chk("restart cmd", 1, n_cmd2);
      chk("restart err", 0, n_err2);
      rst(2'h2, 2'h1, 1'b1);
      cmd(8'h7D, 32'h0, 3'h0);
      chk("spi id raw", 8'h7D, hq[4]);
      chk("spi dev id", 8'h7D, d_id);
      wire_sum(4);
      conclude;
   end
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      $display("unexpected watchdog: expected 0 seen 1");
      conclude;
   end
endmodule
